// file: core/uart_ctl_flow_and_trigger.v
// serial port control: clock gate, rts/cts flow control, fifo triggers
`include "uart_ctl_map.vh"

// Notes on behaviour
// RULE1: module enable clear gates the port clock and idles the block.
// RULE2: manual rts bit set asserts rts, clear makes no request.
// RULE3: manual rts bit is ignored while automatic flow control is on.
// RULE4: autoflow bit makes hardware drive and honour rts/cts.
// RULE5: under autoflow, software rts and cts-check settings are overridden.
// RULE6: rx trigger 00 requests once the rx fifo holds one byte.
// RULE7: rx trigger 01 requests at four bytes, interrupt only.
// RULE8: rx trigger 11 requests at twelve bytes.
// RULE9: software using dma burst must not pick rx trigger 00 or 01.
// RULE10: software using dma single must pick rx trigger 00.
// RULE11: rx trigger 10 requests at eight bytes.
// RULE12: tx trigger requests at 1,4,8,12 free bytes; 00,01 interrupt only.
// RULE13: requests come out only when their enable bit is set.
// RULE14: every control field resets to zero.
module uart_ctl_flow_and_trigger (
	input wire core_clk_in, // 25 MHz block clock
	input wire nrst_in, // async reset, active low
	input wire ce_in, // clock enable, low freezes all state
	input wire [7:0] s_axi_awaddr_in, // write address
	input wire s_axi_awvalid_in, // write address valid
	output reg s_axi_awready_out, // write address ready
	input wire [31:0] s_axi_wdata_in, // write data
	input wire [3:0] s_axi_wstrb_in, // write byte strobes
	input wire s_axi_wvalid_in, // write data valid
	output reg s_axi_wready_out, // write data ready
	output reg [1:0] s_axi_bresp_out, // write response
	output reg s_axi_bvalid_out, // write response valid
	input wire s_axi_bready_in, // write response ready
	input wire [7:0] s_axi_araddr_in, // read address
	input wire s_axi_arvalid_in, // read address valid
	output reg s_axi_arready_out, // read address ready
	output reg [31:0] s_axi_rdata_out, // read data
	output reg [1:0] s_axi_rresp_out, // read response
	output reg s_axi_rvalid_out, // read data valid
	input wire s_axi_rready_in, // read data ready
	input wire [4:0] rx_fifo_level_in, // bytes held in rx fifo, 0..16
	input wire [4:0] tx_fifo_free_in, // free bytes in tx fifo, 0..16
	input wire cts_n_in, // clear-to-send pin, active low
	output reg rts_n_out, // request-to-send pin, active low
	output reg tx_allow_out, // transmitter may start the next byte
	output reg clk_gate_en_out, // enable for the port clock gate
	output reg rx_irq_req_out, // rx interrupt request level
	output reg rx_dma_req_out, // rx dma request level
	output reg tx_irq_req_out, // tx interrupt request level
	output reg tx_dma_req_out, // tx dma request level
	output reg irq_out // unmasked sticky event pending
);
	reg [31:0] ctrl_r;
	reg [`EVT_W-1:0] status_r;
	reg [`EVT_W-1:0] mask_r;
	reg [`EVT_W-1:0] status_nxt;
	reg [7:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	reg aw_have_r;
	reg w_have_r;
	reg rx_hit_r;
	reg tx_hit_r;
	reg cts_prev_r;
	reg miscfg_r;
	reg [31:0] rd_word;
	wire cts_n_sync;

	// fifo level that a two-bit trigger code stands for
	function [`LEVEL_W-1:0] trig_level;
		input [1:0] code;
		begin
			case (code)
				`TRIG_00: trig_level = `LEVEL_1; // RULE6 RULE12
				`TRIG_01: trig_level = `LEVEL_4; // RULE7 RULE12
				`TRIG_10: trig_level = `LEVEL_8; // RULE11 RULE12
				default: trig_level = `LEVEL_12; // RULE8 RULE12
			endcase
		end
	endfunction

	function mapped;
		input [7:0] addr;
		begin
			mapped = (addr == `OFS_CTRL) || (addr == `OFS_IRQ_STATUS) ||
				(addr == `OFS_IRQ_MASK) || (addr == `OFS_STATE);
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
			end
		end
	endfunction

	pin_sync u_cts_sync (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.ce_in(ce_in),
		.reset_val_in(1'b1),
		.pin_in(cts_n_in),
		.sync_out(cts_n_sync)
	);

	wire mod_en = ctrl_r[`BIT_MOD_EN];
	wire auto_flow_enable = ctrl_r[`BIT_AUTO_FLOW];
	wire manual_rts_request = ctrl_r[`BIT_MANUAL_RTS];
	wire cts_check = ctrl_r[`BIT_CTS_CHECK];
	wire [1:0] rx_trigger_level = ctrl_r[`RX_TRIG_HI:`RX_TRIG_LO];
	wire [1:0] tx_trigger_level = ctrl_r[`TX_TRIG_HI:`TX_TRIG_LO];
	wire rx_irq_enable = ctrl_r[`BIT_RX_IRQ_EN];
	wire tx_irq_enable = ctrl_r[`BIT_TX_IRQ_EN];
	wire rx_dma_req_enable = ctrl_r[`BIT_RX_DMA_EN];
	wire tx_dma_req_enable = ctrl_r[`BIT_TX_DMA_EN];

	// a disabled module compares nothing, so all requests fall
	wire rx_hit = mod_en &&
		(rx_fifo_level_in >= trig_level(rx_trigger_level)); // RULE1
	wire tx_hit = mod_en &&
		(tx_fifo_free_in >= trig_level(tx_trigger_level)); // RULE1
	// trigger codes that only serve interrupt mode never raise dma
	wire rx_dma_ok = (rx_trigger_level != `TRIG_01); // RULE7
	wire tx_dma_ok = tx_trigger_level[1]; // RULE12
	wire miscfg = (rx_dma_req_enable && !rx_dma_ok) ||
		(tx_dma_req_enable && !tx_dma_ok);
	wire cts_ok = !cts_n_sync;
	// autoflow stops the remote before the fifo overruns
	wire rts_auto = rx_fifo_level_in < `RTS_STOP_LEVEL;
	wire rts_req = mod_en && (auto_flow_enable ? rts_auto :
		manual_rts_request); // RULE2 RULE3 RULE4 RULE5
	wire tx_ok = mod_en && ((auto_flow_enable || cts_check) ?
		cts_ok : 1'b1); // RULE4 RULE5

	wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
	wire w_take = s_axi_wvalid_in && s_axi_wready_out;
	wire wr_fire = aw_have_r && w_have_r && !s_axi_bvalid_out;
	wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
	wire [31:0] wr_word = merge(32'h0000_0000, w_data_r, w_strb_r);

	// write channel
	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `RESP_OKAY;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (ce_in) begin
			if (aw_take) begin
				aw_addr_r <= s_axi_awaddr_in;
				aw_have_r <= 1'b1;
				s_axi_awready_out <= 1'b0;
			end else if (!aw_have_r && !s_axi_bvalid_out) begin
				s_axi_awready_out <= 1'b1;
			end
			if (w_take) begin
				w_data_r <= s_axi_wdata_in;
				w_strb_r <= s_axi_wstrb_in;
				w_have_r <= 1'b1;
				s_axi_wready_out <= 1'b0;
			end else if (!w_have_r && !s_axi_bvalid_out) begin
				s_axi_wready_out <= 1'b1;
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= mapped(aw_addr_r) ?
					`RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	always @* begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr_in)
			`OFS_CTRL: rd_word = ctrl_r;
			`OFS_IRQ_STATUS: rd_word[`EVT_W-1:0] = status_r;
			`OFS_IRQ_MASK: rd_word[`EVT_W-1:0] = mask_r;
			// snapshot of pins and fifo levels, unused bits read 0
			`OFS_STATE: begin
				rd_word[`ST_RX_HI:`ST_RX_LO] = rx_fifo_level_in;
				rd_word[`ST_TX_HI:`ST_TX_LO] = tx_fifo_free_in;
				rd_word[`ST_GATE] = clk_gate_en_out;
				rd_word[`ST_ALLOW] = tx_allow_out;
				rd_word[`ST_CTS] = cts_n_sync;
				rd_word[`ST_RTS] = rts_n_out;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// read channel, answer one cycle after the address is taken
	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= `RESP_OKAY;
		end else if (ce_in) begin
			if (ar_take) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= rd_word;
				s_axi_rresp_out <= mapped(s_axi_araddr_in) ?
					`RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end else if (!s_axi_rvalid_out) begin
				s_axi_arready_out <= 1'b1;
			end
		end
	end

	// sticky events: a set in the clearing cycle survives the clear
	always @* begin
		status_nxt = status_r;
		if (wr_fire && aw_addr_r == `OFS_IRQ_STATUS)
			status_nxt = status_nxt & ~wr_word[`EVT_W-1:0];
		if (rx_hit && !rx_hit_r)
			status_nxt[`EVT_RX_TRIG] = 1'b1;
		if (tx_hit && !tx_hit_r)
			status_nxt[`EVT_TX_TRIG] = 1'b1;
		if (cts_n_sync != cts_prev_r)
			status_nxt[`EVT_CTS_CHANGE] = 1'b1;
		if (miscfg && !miscfg_r)
			status_nxt[`EVT_DMA_MISCFG] = 1'b1; // RULE9 RULE10
	end

	// control registers and flow outputs
	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_r <= `CTRL_RESET; // RULE14
			status_r <= `EVT_RESET;
			mask_r <= `EVT_RESET;
			rx_hit_r <= 1'b0;
			tx_hit_r <= 1'b0;
			cts_prev_r <= 1'b1;
			miscfg_r <= 1'b0;
			rts_n_out <= 1'b1;
			tx_allow_out <= 1'b0;
			clk_gate_en_out <= 1'b0;
			rx_irq_req_out <= 1'b0;
			rx_dma_req_out <= 1'b0;
			tx_irq_req_out <= 1'b0;
			tx_dma_req_out <= 1'b0;
			irq_out <= 1'b0;
		end else if (ce_in) begin
			if (wr_fire && aw_addr_r == `OFS_CTRL)
				ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) &
					`CTRL_WR_MASK;
			// the mask bits all sit in byte lane 0
			if (wr_fire && aw_addr_r == `OFS_IRQ_MASK && w_strb_r[0])
				mask_r <= w_data_r[`EVT_W-1:0];
			status_r <= status_nxt;
			rx_hit_r <= rx_hit;
			tx_hit_r <= tx_hit;
			cts_prev_r <= cts_n_sync;
			miscfg_r <= miscfg;
			clk_gate_en_out <= mod_en; // RULE1
			rts_n_out <= !rts_req; // RULE2 RULE3
			tx_allow_out <= tx_ok; // RULE5
			rx_irq_req_out <= rx_hit && rx_irq_enable; // RULE13
			tx_irq_req_out <= tx_hit && tx_irq_enable; // RULE13
			rx_dma_req_out <= rx_hit && rx_dma_ok &&
				rx_dma_req_enable; // RULE13
			tx_dma_req_out <= tx_hit && tx_dma_ok &&
				tx_dma_req_enable; // RULE13
			irq_out <= |(status_nxt & mask_r);
		end
	end
endmodule // uart_ctl_flow_and_trigger

// file: core/uart_ctl_map.vh
// register map, field positions and levels for the serial control block
`ifndef UART_CTL_MAP_VH
`define UART_CTL_MAP_VH

`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_STATE 8'h0C

`define CTRL_WR_MASK 32'h000F_BF80
`define CTRL_RESET 32'h0000_0000
`define BIT_TX_IRQ_EN 19
`define BIT_RX_IRQ_EN 18
`define BIT_TX_DMA_EN 17
`define BIT_RX_DMA_EN 16
`define BIT_MOD_EN 15
`define BIT_MANUAL_RTS 13
`define BIT_AUTO_FLOW 12
`define RX_TRIG_HI 11
`define RX_TRIG_LO 10
`define TX_TRIG_HI 9
`define TX_TRIG_LO 8
`define BIT_CTS_CHECK 7

`define ST_RX_HI 4
`define ST_RX_LO 0
`define ST_TX_HI 12
`define ST_TX_LO 8
`define ST_GATE 16
`define ST_ALLOW 17
`define ST_CTS 18
`define ST_RTS 19

`define EVT_W 4
`define EVT_RX_TRIG 0
`define EVT_TX_TRIG 1
`define EVT_CTS_CHANGE 2
`define EVT_DMA_MISCFG 3
`define EVT_RESET 4'h0

`define TRIG_00 2'h0
`define TRIG_01 2'h1
`define TRIG_10 2'h2
`define TRIG_11 2'h3
`define LEVEL_W 5
`define LEVEL_1 5'h01
`define LEVEL_4 5'h04
`define LEVEL_8 5'h08
`define LEVEL_12 5'h0C
`define RTS_STOP_LEVEL 5'h0E

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: core/pin_sync.v
// two flip-flop synchroniser for one pin level
module pin_sync (
	input wire core_clk_in, // block clock
	input wire nrst_in, // async reset, active low
	input wire ce_in, // clock enable
	input wire reset_val_in, // reset level input, unused; both stages reset to 1
	input wire pin_in, // asynchronous pin
	output reg sync_out // synchronised level
);
	reg stage1_r;

	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stage1_r <= 1'b1;
			sync_out <= 1'b1;
		end else if (ce_in) begin
			stage1_r <= pin_in;
			sync_out <= stage1_r;
		end
	end
endmodule // pin_sync

// file: bench/uart_ctl_props.sv
// port-level assertions for the serial control block
module uart_ctl_props (
	input wire core_clk_in, // clock
	input wire nrst_in, // reset
	input wire s_axi_awvalid_in, // aw
	input wire s_axi_awready_out, // aw
	input wire s_axi_wvalid_in, // w
	input wire s_axi_wready_out, // w
	input wire s_axi_bvalid_out, // b
	input wire s_axi_bready_in, // b
	input wire [1:0] s_axi_bresp_out, // b
	input wire s_axi_arvalid_in, // ar
	input wire s_axi_arready_out, // ar
	input wire s_axi_rvalid_out, // r
	input wire s_axi_rready_in, // r
	input wire [31:0] s_axi_rdata_out, // r
	input wire [4:0] rx_fifo_level_in, // rx
	input wire [4:0] tx_fifo_free_in, // tx
	input wire tx_allow_out, // tx
	input wire clk_gate_en_out, // en
	input wire rx_irq_req_out, // req
	input wire rx_dma_req_out, // req
	input wire tx_irq_req_out, // req
	input wire tx_dma_req_out // req
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	property p_gate;
		!clk_gate_en_out && $past(!clk_gate_en_out) |-> !(tx_allow_out |
		rx_irq_req_out | rx_dma_req_out | tx_irq_req_out | tx_dma_req_out);
	endproperty
	a_gate: assert property (p_gate) else $error("request while gated");
	property p_rxreq;
		rx_irq_req_out | rx_dma_req_out |-> $past(rx_fifo_level_in) != 0;
	endproperty
	a_rxreq: assert property (p_rxreq) else $error("rx req, empty");
	property p_txdma;
		tx_dma_req_out |-> $past(tx_fifo_free_in) >= 8;
	endproperty
	a_txdma: assert property (p_txdma) else $error("tx dma below 8");
	property p_txirq;
		tx_irq_req_out |-> $past(tx_fifo_free_in) != 0;
	endproperty
	a_txirq: assert property (p_txirq) else $error("tx irq, no room");
	property p_wresp;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
		s_axi_wready_out |-> ##2 s_axi_bvalid_out;
	endproperty
	a_wresp: assert property (p_wresp) else $error("no write response");
	property p_rresp;
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
	endproperty
	a_rresp: assert property (p_rresp) else $error("no read response");
	property p_bhold;
		s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out);
	endproperty
	a_bhold: assert property (p_bhold) else $error("bresp dropped");
	property p_rhold;
		s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	a_rhold: assert property (p_rhold) else $error("rdata dropped");
	c_rxdma: cover property (rx_dma_req_out);
	c_txdma: cover property (tx_dma_req_out);
	c_allow: cover property (tx_allow_out && clk_gate_en_out);
endmodule // uart_ctl_props

bind uart_ctl_flow_and_trigger uart_ctl_props i_props (.*);

// file: bench/remote_uart.sv
// remote transceiver side of the rts/cts handshake
module remote_uart (
	input wire clk_in, // bench clock
	input wire busy_in, // far side cannot take data
	input wire slow_in, // answer three clocks late
	output wire cts_n_out // clear-to-send, active low
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [2:0] lag_r = 3'h7;
	always @(posedge clk_in) lag_r <= {lag_r[1:0], busy_in};
	assign cts_n_out = slow_in ? lag_r[2] : busy_in;
endmodule // remote_uart

// file: bench/testbench.sv
// self-checking bench for the serial control block
`include "uart_ctl_map.vh"
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin bad_count++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	reg clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
	reg arv = 1'b0, rready = 1'b0, busy = 1'b0, slow = 1'b0;
	reg ce = 1'b1;
	reg [6:0] want;
	reg [31:0] st;
	reg [7:0] awaddr = 8'h00, araddr = 8'h00;
	reg [31:0] wdata = 32'h0000_0000, ctrl = 32'h0000_0000, rd;
	reg [4:0] rxl = 5'h00, txf = 5'h00;
	reg [1:0] resp;
	wire awr, wrdy, bv, arr, rv, cts_n, rts_n, txa, gate, rxi, rxd, txi;
	wire txd, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int bad_count = 0, checks = 0, cyc = 0, seed = 32'h0000_6a7e, i;
	uart_ctl_flow_and_trigger i_uart_ctl_flow_and_trigger (
		.core_clk_in(clk), .nrst_in(nrst), .ce_in(ce),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rready),
		.rx_fifo_level_in(rxl), .tx_fifo_free_in(txf), .cts_n_in(cts_n),
		.rts_n_out(rts_n), .tx_allow_out(txa), .clk_gate_en_out(gate),
		.rx_irq_req_out(rxi), .rx_dma_req_out(rxd), .tx_irq_req_out(txi),
		.tx_dma_req_out(txd), .irq_out(irq));
	remote_uart i_far (.clk_in(clk), .busy_in(busy), .slow_in(slow),
		.cts_n_out(cts_n));
	initial forever #20 clk = ~clk;
	// {rts_n, tx_allow, gate, rx irq, rx dma, tx irq, tx dma}
	function automatic [6:0] model(input [31:0] c, input [4:0] l, f,
		input cn);
		int th[4] = '{1, 4, 8, 12};
		reg en, rh, fh;
		begin
			en = c[15];
			rh = l >= th[c[11:10]];
			fh = f >= th[c[9:8]];
			model = {!en | (c[12] ? l >= `RTS_STOP_LEVEL : !c[13]),
				en & (!(c[12] | c[7]) | !cn), en, en & c[18] & rh,
				en & c[16] & rh & c[11:10] != 1, en & c[19] & fh,
				en & c[17] & fh & c[9]};
		end
	endfunction
	task test_done;
		begin
			$display("checks %0d mismatches %0d", checks, bad_count);
			if (bad_count == 0 && checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			test_done;
		end
	end
	task wr(input [7:0] a, input [31:0] d);
		reg pa, pw;
		begin
			pa = 1;
			pw = 1;
			awaddr <= a;
			wdata <= d;
			awv <= 1;
			wv <= 1;
			while (pa | pw) begin
				@(posedge clk);
				if (pa & awr) begin
					awv <= 0;
					pa = 0;
				end
				if (pw & wrdy) begin
					wv <= 0;
					pw = 0;
				end
			end
			do @(posedge clk); while (!bv);
			bready <= 1;
			@(posedge clk);
			resp = bresp;
			bready <= 0;
		end
	endtask
	task rdreg(input [7:0] a);
		begin
			araddr <= a;
			arv <= 1;
			do @(posedge clk); while (!arr);
			arv <= 0;
			do @(posedge clk); while (!rv);
			rready <= 1;
			@(posedge clk);
			rd = rdata;
			resp = rresp;
			rready <= 0;
		end
	endtask
	task irq_chk(input [7:0] a, input [31:0] d, input e);
		begin
			wr(a, d);
			repeat (3) @(posedge clk);
			`CHK("irq", e, irq)
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		`CHK("outputs", model(0, 0, 0, 0), {rts_n, txa, gate, rxi, rxd, txi, txd})
		rdreg(`OFS_CTRL);
		`CHK("ctrl", 32'h0000_0000, rd)
		wr(8'h10, 32'hffff_ffff);
		`CHK("bresp", `RESP_SLVERR, resp)
		rdreg(8'h10);
		`CHK("rresp", {`RESP_SLVERR, 32'h0000_0000}, {resp, rd})
		for (i = 0; i < 64; i++) begin
			rxl <= 5'({$random(seed)} % 17);
			txf <= 5'({$random(seed)} % 17);
			busy <= 1'($random(seed));
			slow <= 1'($random(seed));
			rd = $random(seed);
			rd[11:8] = i[3:0];
			rd[15] = rd[15] | (i < 16);
			ctrl = rd & `CTRL_WR_MASK;
			wr(`OFS_CTRL, rd);
			`CHK("bresp", `RESP_OKAY, resp)
			repeat (8) @(posedge clk);
			want = model(ctrl, rxl, txf, busy);
			`CHK("outputs", want, {rts_n, txa, gate, rxi, rxd, txi, txd})
			rdreg(`OFS_CTRL);
			`CHK("ctrl", {`RESP_OKAY, ctrl}, {resp, rd})
			st = {12'h000, want[6], busy, want[5:4], 3'h0, txf,
				3'h0, rxl};
			rdreg(`OFS_STATE);
			`CHK("state", st, rd)
		end
		rxl <= 0;
		wr(`OFS_CTRL, 32'h0004_8000);
		wr(`OFS_IRQ_STATUS, 32'h0000_000f);
		irq_chk(`OFS_IRQ_MASK, 32'h0000_0001, 0);
		rxl <= 1;
		irq_chk(`OFS_IRQ_MASK, 32'h0000_0001, 1);
		rdreg(`OFS_IRQ_STATUS);
		`CHK("rx event", 1'b1, rd[0])
		irq_chk(`OFS_IRQ_MASK, 32'h0000_0000, 0);
		irq_chk(`OFS_IRQ_MASK, 32'h0000_0001, 1);
		irq_chk(`OFS_IRQ_STATUS, 32'h0000_0001, 0);
		// dma single mode keeps code 00, burst mode a code of 8 or more
		wr(`OFS_CTRL, 32'h0001_8000);
		repeat (3) @(posedge clk);
		`CHK("rx dma single", 1'b1, rxd)
		rxl <= 7;
		wr(`OFS_CTRL, 32'h0001_8800);
		repeat (3) @(posedge clk);
		`CHK("rx dma burst", 1'b0, rxd)
		ce <= 0;
		rxl <= 8;
		repeat (4) @(posedge clk);
		`CHK("rx dma frozen", 1'b0, rxd)
		ce <= 1;
		repeat (3) @(posedge clk);
		`CHK("rx dma burst", 1'b1, rxd)
		test_done;
	end
endmodule // testbench
